// ---- rtl/adsq_top.sv ----
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Pause between samples lasts the gap field plus one converter ticks, unscaled.
// - Auto vary bit makes hardware change the gap field each sample.
// - Window mode: none, below, above, inside, outside; others reserved.
// - Sampling lasts two ticks plus the sample extension field.
// - Input code selects pins 0-15, comparator reference, thermal input or ground.
// - Input change during a conversion applies only after it completes.
// - Writing start bit starts one measurement, or the first continuous one.
// - Start bit reads one while converting, cleared by hardware at completion unless continuous.
// - With event start enabled, an event starts a conversion like software.
// - Each interrupt request needs its enable: bit 1 window, bit 0 ready.
// - Window comparison happens once at conversion end, flag set on match.
// - Result ready flag sets when a new result lands in the result register.
// - Flags clear on writing one or reading the result; zero does nothing.
// - Debug run 0 during CPU halt freezes sample and gap timing, lets a running conversion finish and ignores events; 1 keeps running.
// - One shared byte staging register serves 16-bit accesses, also direct.
// - 16-bit registers: low byte at base, high byte at base plus one.
// - Each 10-bit sample clamps to 0x3FF above reference, 0x000 below zero.
// - Accumulated 16-bit unsigned result never exceeds 0xFFC0.
// - Window compares the final accumulated sum, not single samples.
// - Auto vary increments the gap by one per sample, wrapping 0xF to 0x0.
// - Continuous mode starts the next conversion after the gap pause that follows completion.
// - Accumulation codes 1-6 sum 2 to 64 samples; 0 none, 7 reserved.
// - Eight-bit mode drops two low bits of each sample before use.
module adsq_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic event_in,
  input wire logic cpu_halted,
  input wire logic core_valid,
  input wire logic signed [11:0] core_code,
  output adsq_pkg::adsq_core_cmd_t core_cmd,
  output logic irq_result_ready,
  output logic irq_window_match
);
  logic [2:0] ctrl;
  logic [2:0] accumulation_count;
  logic gap_auto_vary;
  logic [3:0] sample_gap_cycles;
  logic [2:0] window_mode_sel;
  logic [4:0] sample_extension;
  logic [4:0] input_selector;
  logic event_start_enable;
  logic [1:0] irq_enable;
  logic [1:0] irq_flags;
  logic run_during_halt;
  logic [7:0] staging;
  logic [15:0] result_value;
  logic [15:0] window_low_limit;
  logic [15:0] window_high_limit;
  logic [5:0] aw_ix;
  logic [7:0] wd;
  logic w_lane;
  logic do_wr;
  logic rd_take;
  logic [5:0] ar_ix;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic res_rd;
  logic [2:0] ev_s;
  logic ev_lvl;
  logic ev_pulse;
  logic tick_cnt;
  logic tick;
  logic halted;
  adsq_pkg::adsq_state_t state;
  logic [5:0] tcnt;
  logic [6:0] n;
  logic [15:0] sum;
  logic busy;
  logic seq_done;
  logic win_hit;
  logic gap_step;
  logic start_req;
  logic [9:0] val10;
  logic [9:0] val;
  logic [15:0] sum_next;
  logic [2:0] acc_eff;
  logic [6:0] acc_last;

  function automatic logic wen(input logic [5:0] ix);
    return do_wr && w_lane && aw_ix == ix;
  endfunction

  function automatic logic mapped(input logic [5:0] ix);
    logic m;
    m = 1'b1;
    if (ix == adsq_pkg::IX_CTRL || ix == adsq_pkg::IX_ACC || ix == adsq_pkg::IX_GAP) begin
      m = 1'b1;
    end else if (ix >= adsq_pkg::IX_WINMODE && ix <= adsq_pkg::IX_INSEL) begin
      m = 1'b1;
    end else if (ix >= adsq_pkg::IX_CMD && ix <= adsq_pkg::IX_STAGE) begin
      m = 1'b1;
    end else if (ix >= adsq_pkg::IX_RES && ix <= adsq_pkg::IX_WINHI + adsq_pkg::IX_HIGH) begin
      m = 1'b1;
    end else begin
      m = 1'b0;
    end
    return m;
  endfunction

  function automatic logic [4:0] route(input logic [4:0] sel);
    logic [4:0] r;
    r = adsq_pkg::MUX_GND;
    if (sel <= adsq_pkg::MUX_PIN_LAST || sel == adsq_pkg::MUX_DACREF || sel == adsq_pkg::MUX_TEMP) begin
      r = sel;
    end
    return r;
  endfunction

  function automatic logic win_ok(input logic [2:0] m, input logic [15:0] r,
                                  input logic [15:0] lo, input logic [15:0] hi);
    logic k;
    case (m)
      adsq_pkg::WM_BELOW: k = r < lo;
      adsq_pkg::WM_ABOVE: k = r > hi;
      adsq_pkg::WM_INSIDE: k = r > lo && r < hi;
      adsq_pkg::WM_OUTSIDE: k = r < lo || r > hi;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  // Bus write side: address and data taken in either order
  assign do_wr = !s_awready && !s_wready && !s_bvalid;
  assign rd_take = s_arvalid && s_arready;
  assign ar_ix = s_araddr[7:2];
  assign res_rd = rd_take && ar_ix == adsq_pkg::IX_RES;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= adsq_pkg::RESP_OK;
      aw_ix <= '0;
      wd <= adsq_pkg::RST8;
      w_lane <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        aw_ix <= s_awaddr[7:2];
      end else if (do_wr) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        wd <= s_wdata[7:0];
        w_lane <= s_wstrb[0];
      end else if (do_wr) begin
        s_wready <= 1'b1;
      end
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp <= mapped(aw_ix) ? adsq_pkg::RESP_OK : adsq_pkg::RESP_ERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_byte = adsq_pkg::RST8;
    if (ar_ix == adsq_pkg::IX_CTRL) begin
      rd_byte = {5'h00, ctrl};
    end else if (ar_ix == adsq_pkg::IX_ACC) begin
      rd_byte = {5'h00, accumulation_count};
    end else if (ar_ix == adsq_pkg::IX_GAP) begin
      rd_byte = {3'h0, gap_auto_vary, sample_gap_cycles};
    end else if (ar_ix == adsq_pkg::IX_WINMODE) begin
      rd_byte = {5'h00, window_mode_sel};
    end else if (ar_ix == adsq_pkg::IX_SAMPLE_EXTENSION) begin
      rd_byte = {3'h0, sample_extension};
    end else if (ar_ix == adsq_pkg::IX_INSEL) begin
      rd_byte = {3'h0, input_selector};
    end else if (ar_ix == adsq_pkg::IX_CMD) begin
      rd_byte = {7'h00, busy};
    end else if (ar_ix == adsq_pkg::IX_EVENT_TRIGGER_CTRL) begin
      rd_byte = {7'h00, event_start_enable};
    end else if (ar_ix == adsq_pkg::IX_IRQEN) begin
      rd_byte = {6'h00, irq_enable};
    end else if (ar_ix == adsq_pkg::IX_FLAGS) begin
      rd_byte = {6'h00, irq_flags};
    end else if (ar_ix == adsq_pkg::IX_DBG) begin
      rd_byte = {7'h00, run_during_halt};
    end else if (ar_ix == adsq_pkg::IX_STAGE) begin
      rd_byte = staging;
    end else if (ar_ix == adsq_pkg::IX_RES) begin
      rd_byte = result_value[7:0];
    end else if (ar_ix == adsq_pkg::IX_WINLO) begin
      rd_byte = window_low_limit[7:0];
    end else if (ar_ix == adsq_pkg::IX_WINHI) begin
      rd_byte = window_high_limit[7:0];
    end else if (mapped(ar_ix)) begin
      rd_byte = staging;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= adsq_pkg::RESP_OK;
    end else if (rd_take) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= {24'h000000, rd_byte};
      s_rresp <= rd_ok ? adsq_pkg::RESP_OK : adsq_pkg::RESP_ERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= '0;
      accumulation_count <= adsq_pkg::ACC_NONE;
      window_mode_sel <= adsq_pkg::WM_NONE;
      sample_extension <= '0;
      input_selector <= '0;
      event_start_enable <= 1'b0;
      irq_enable <= '0;
      run_during_halt <= 1'b0;
    end else begin
      if (wen(adsq_pkg::IX_CTRL)) ctrl <= wd[2:0];
      if (wen(adsq_pkg::IX_ACC)) accumulation_count <= wd[2:0];
      if (wen(adsq_pkg::IX_WINMODE)) window_mode_sel <= wd[2:0];
      if (wen(adsq_pkg::IX_SAMPLE_EXTENSION)) sample_extension <= wd[4:0];
      if (wen(adsq_pkg::IX_INSEL)) input_selector <= wd[4:0];
      if (wen(adsq_pkg::IX_EVENT_TRIGGER_CTRL)) event_start_enable <= wd[0];
      if (wen(adsq_pkg::IX_IRQEN)) irq_enable <= wd[1:0];
      if (wen(adsq_pkg::IX_DBG)) run_during_halt <= wd[0];
    end
  end

  // Gap field: software write wins over the hardware step
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap_auto_vary <= 1'b0;
      sample_gap_cycles <= '0;
    end else if (wen(adsq_pkg::IX_GAP)) begin
      gap_auto_vary <= wd[adsq_pkg::B_VARY];
      sample_gap_cycles <= wd[3:0];
    end else if (gap_step) begin
      sample_gap_cycles <= sample_gap_cycles + 4'h1;
    end
  end

  // Staging byte and 16-bit threshold pairs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      staging <= adsq_pkg::RST8;
      window_low_limit <= adsq_pkg::RST16;
      window_high_limit <= adsq_pkg::RST16;
    end else begin
      if (wen(adsq_pkg::IX_STAGE) || wen(adsq_pkg::IX_WINLO) || wen(adsq_pkg::IX_WINHI)) begin
        staging <= wd;
      end else if (res_rd) begin
        staging <= result_value[15:8];
      end else if (rd_take && ar_ix == adsq_pkg::IX_WINLO) begin
        staging <= window_low_limit[15:8];
      end else if (rd_take && ar_ix == adsq_pkg::IX_WINHI) begin
        staging <= window_high_limit[15:8];
      end
      if (wen(adsq_pkg::IX_WINLO + adsq_pkg::IX_HIGH)) window_low_limit <= {wd, staging};
      if (wen(adsq_pkg::IX_WINHI + adsq_pkg::IX_HIGH)) window_high_limit <= {wd, staging};
    end
  end

  // Flags: hardware set wins over clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_flags <= '0;
      irq_result_ready <= 1'b0;
      irq_window_match <= 1'b0;
    end else begin
      irq_flags <= {win_hit, seq_done} | (irq_flags & ~((wen(adsq_pkg::IX_FLAGS) ? wd[1:0] : 2'h0) |
                   {2{res_rd}}));
      irq_result_ready <= irq_flags[adsq_pkg::B_RDY] && irq_enable[adsq_pkg::B_RDY];
      irq_window_match <= irq_flags[adsq_pkg::B_WIN] && irq_enable[adsq_pkg::B_WIN];
    end
  end

  // Event pin synchroniser
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ev_s <= '0;
      ev_lvl <= 1'b0;
      ev_pulse <= 1'b0;
    end else begin
      ev_s <= {ev_s[1:0], event_in};
      if (ev_s[1] == ev_s[2]) ev_lvl <= ev_s[2];
      ev_pulse <= ev_s[1] == ev_s[2] && ev_s[2] && !ev_lvl;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) tick_cnt <= 1'b0;
    else tick_cnt <= tick_cnt == adsq_pkg::TICK_LAST ? 1'b0 : tick_cnt + 1'b1;
  end
  assign tick = tick_cnt == adsq_pkg::TICK_LAST;

  assign halted = cpu_halted && !run_during_halt;
  // Inline decode; a function hides its reads from a continuous assignment
  assign start_req = !halted && ((do_wr && w_lane && aw_ix == adsq_pkg::IX_CMD && wd[0]) ||
                     (ev_pulse && event_start_enable));
  assign val10 = core_code < 0 ? 10'h000 :
                 core_code > $signed({2'b00, adsq_pkg::CODE_MAX}) ? adsq_pkg::CODE_MAX :
                 core_code[9:0];
  assign val = ctrl[adsq_pkg::B_RES8] ? {2'b00, val10[9:2]} : val10;
  assign sum_next = sum + {6'h00, val};
  assign acc_eff = accumulation_count == adsq_pkg::ACC_RSVD ? adsq_pkg::ACC_NONE : accumulation_count;
  assign acc_last = (7'h01 << acc_eff) - 7'h01;

  // Conversion sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= adsq_pkg::SQ_IDLE;
      tcnt <= '0;
      n <= '0;
      sum <= adsq_pkg::RST16;
      result_value <= adsq_pkg::RST16;
      busy <= 1'b0;
      seq_done <= 1'b0;
      win_hit <= 1'b0;
      gap_step <= 1'b0;
      core_cmd <= '0;
    end else begin
      seq_done <= 1'b0;
      win_hit <= 1'b0;
      gap_step <= 1'b0;
      core_cmd.conv_start <= 1'b0;
      if (!ctrl[adsq_pkg::B_EN]) begin
        state <= adsq_pkg::SQ_IDLE;
        busy <= 1'b0;
        core_cmd.sample_en <= 1'b0;
      end else begin
        case (state)
          adsq_pkg::SQ_IDLE: begin
            if (start_req) begin
              state <= adsq_pkg::SQ_SAMPLE;
              busy <= 1'b1;
              core_cmd.mux_sel <= route(input_selector);
              core_cmd.sample_en <= 1'b1;
              tcnt <= '0;
              n <= '0;
              sum <= adsq_pkg::RST16;
            end
          end
          adsq_pkg::SQ_GAP: begin
            if (!halted && tick) begin
              if (tcnt >= {2'b00, sample_gap_cycles}) begin
                state <= adsq_pkg::SQ_SAMPLE;
                core_cmd.sample_en <= 1'b1;
                tcnt <= '0;
              end else begin
                tcnt <= tcnt + 6'h01;
              end
            end
          end
          adsq_pkg::SQ_SAMPLE: begin
            if (!halted && tick) begin
              if (tcnt == adsq_pkg::SAMP_BASE + {1'b0, sample_extension} - 6'h01) begin
                state <= adsq_pkg::SQ_CONV;
                core_cmd.sample_en <= 1'b0;
                core_cmd.conv_start <= 1'b1;
                gap_step <= gap_auto_vary;
              end else begin
                tcnt <= tcnt + 6'h01;
              end
            end
          end
          default: begin
            if (core_valid) begin
              tcnt <= '0;
              if (n == acc_last) begin
                result_value <= sum_next;
                seq_done <= 1'b1;
                win_hit <= win_ok(window_mode_sel, sum_next, window_low_limit, window_high_limit);
                n <= '0;
                sum <= adsq_pkg::RST16;
                if (ctrl[adsq_pkg::B_FREE]) begin
                  state <= adsq_pkg::SQ_GAP;
                  core_cmd.mux_sel <= route(input_selector);
                end else begin
                  state <= adsq_pkg::SQ_IDLE;
                  busy <= 1'b0;
                end
              end else begin
                sum <= sum_next;
                n <= n + 7'h01;
                state <= adsq_pkg::SQ_GAP;
              end
            end
          end
        endcase
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence samp_enter_s;
    state != adsq_pkg::SQ_SAMPLE ##1 state == adsq_pkg::SQ_SAMPLE;
  endsequence
  sequence samp_hold_s;
    state == adsq_pkg::SQ_SAMPLE [*3];
  endsequence

  gap_len_a: assert property (state == adsq_pkg::SQ_GAP && tick && !halted && ctrl[adsq_pkg::B_EN] &&
    tcnt < {2'b00, sample_gap_cycles} |=> state == adsq_pkg::SQ_GAP) else $error("gap ended early");
  gap_vary_a: assert property (gap_step && !(do_wr && w_lane && aw_ix == adsq_pkg::IX_GAP) |=>
    sample_gap_cycles == 4'($past(sample_gap_cycles) + 4'h1)) else $error("gap not stepped");
  win_none_a: assert property (seq_done && $past(window_mode_sel) > adsq_pkg::WM_OUTSIDE |->
    !win_hit) else $error("reserved mode matched");
  samp_len_a: assert property (samp_enter_s |-> samp_hold_s) else $error("sample too short");
  mux_hold_a: assert property (state == adsq_pkg::SQ_CONV && $past(state) == adsq_pkg::SQ_SAMPLE |->
    $stable(core_cmd.mux_sel)) else $error("input changed mid conversion");
  done_clear_a: assert property (seq_done && !$past(ctrl[adsq_pkg::B_FREE]) |-> !busy)
    else $error("start bit not cleared");
  flag_set_a: assert property (seq_done |=> irq_flags[adsq_pkg::B_RDY]) else $error("ready flag lost");
  irq_gate_a: assert property (!irq_enable[adsq_pkg::B_WIN] ##1 !irq_enable[adsq_pkg::B_WIN] |->
    !irq_window_match) else $error("masked irq raised");
  clamp_max_a: assert property (state == adsq_pkg::SQ_CONV && core_valid && ctrl[adsq_pkg::B_EN] &&
    !ctrl[adsq_pkg::B_RES8] && acc_last == 7'h00 && core_code > $signed({2'b00, adsq_pkg::CODE_MAX}) |=>
    result_value == {6'h00, adsq_pkg::CODE_MAX}) else $error("sample over range");
  acc_max_a: assert property (result_value <= adsq_pkg::ACC_MAX) else $error("sum over limit");
  halt_idle_a: assert property (halted && state == adsq_pkg::SQ_IDLE |=>
    state == adsq_pkg::SQ_IDLE) else $error("started while halted");
endmodule

// ---- rtl/adsq_pkg.sv ----
package adsq_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IX_CTRL = 6'h00;
  localparam logic [5:0] IX_ACC = 6'h01;
  localparam logic [5:0] IX_GAP = 6'h03;
  localparam logic [5:0] IX_WINMODE = 6'h04;
  localparam logic [5:0] IX_SAMPLE_EXTENSION = 6'h05;
  localparam logic [5:0] IX_INSEL = 6'h06;
  localparam logic [5:0] IX_CMD = 6'h08;
  localparam logic [5:0] IX_EVENT_TRIGGER_CTRL = 6'h09;
  localparam logic [5:0] IX_IRQEN = 6'h0a;
  localparam logic [5:0] IX_FLAGS = 6'h0b;
  localparam logic [5:0] IX_DBG = 6'h0c;
  localparam logic [5:0] IX_STAGE = 6'h0d;
  localparam logic [5:0] IX_RES = 6'h10;
  localparam logic [5:0] IX_WINLO = 6'h12;
  localparam logic [5:0] IX_WINHI = 6'h14;
  localparam logic [5:0] IX_HIGH = 6'h01;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Bit positions: control register, gap vary bit, flag and enable bits
  localparam int B_EN = 0;
  localparam int B_FREE = 1;
  localparam int B_RES8 = 2;
  localparam int B_VARY = 4;
  localparam int B_RDY = 0;
  localparam int B_WIN = 1;
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [2:0] WM_NONE = 3'h0;
  localparam logic [2:0] WM_BELOW = 3'h1;
  localparam logic [2:0] WM_ABOVE = 3'h2;
  localparam logic [2:0] WM_INSIDE = 3'h3;
  localparam logic [2:0] WM_OUTSIDE = 3'h4;
  localparam logic [2:0] ACC_NONE = 3'h0;
  localparam logic [2:0] ACC_RSVD = 3'h7;
  localparam logic [4:0] MUX_PIN_LAST = 5'h0f;
  localparam logic [4:0] MUX_DACREF = 5'h1c;
  localparam logic [4:0] MUX_TEMP = 5'h1e;
  localparam logic [4:0] MUX_GND = 5'h1f;
  localparam logic [5:0] SAMP_BASE = 6'h02;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [15:0] ACC_MAX = 16'hffc0;
  // Converter tick divides core_clk by two
  localparam logic [0:0] TICK_LAST = 1'h1;

  typedef enum {SQ_IDLE, SQ_GAP, SQ_SAMPLE, SQ_CONV} adsq_state_t;

  typedef struct packed {
    logic sample_en;
    logic conv_start;
    logic [4:0] mux_sel;
  } adsq_core_cmd_t;
endpackage

// ---- tb/adsq_core_model.sv ----
`timescale 1ns/1ps
module adsq_core_model (
  input wire logic core_clk,
  input wire logic rstn,
  input adsq_pkg::adsq_core_cmd_t core_cmd,
  input wire logic signed [11:0] code_in,
  output logic core_valid,
  output logic signed [11:0] core_code
);
  logic busy;
  logic slow;
  logic [3:0] wait_cnt;
  // Alternates prompt and slow answers; code toggles when not presented
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      slow <= 1'b0;
      wait_cnt <= 4'h0;
      core_valid <= 1'b0;
      core_code <= 12'h000;
    end else begin
      core_valid <= 1'b0;
      core_code <= ~core_code;
      if (core_cmd.conv_start) begin
        busy <= 1'b1;
        slow <= ~slow;
        wait_cnt <= slow ? 4'h9 : 4'h1;
      end else if (busy && wait_cnt == 4'h0) begin
        busy <= 1'b0;
        core_valid <= 1'b1;
        core_code <= code_in;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule

// ---- tb/adsq_top_tb.sv ----
`timescale 1ns/1ps
module adsq_top_tb;
  logic core_clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, event_in, cpu_halted;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, core_valid, irq_result_ready, irq_window_match;
  logic [7:0] s_awaddr, s_araddr, rd_v;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp, ien;
  logic signed [11:0] core_code, code_in;
  adsq_pkg::adsq_core_cmd_t core_cmd;
  int miscompares, tests_run, code, n;
  logic [2:0] acc, wm;
  logic [4:0] ext, mux;
  logic [3:0] gap;
  logic r8, vary, match;
  logic [15:0] lo, hi, r;
  logic [5:0] rst_ix [11] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h10, 6'h12};

  adsq_top dut (.core_clk(core_clk), .rstn(rstn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .event_in(event_in), .cpu_halted(cpu_halted), .core_valid(core_valid), .core_code(core_code),
    .core_cmd(core_cmd), .irq_result_ready(irq_result_ready), .irq_window_match(irq_window_match));
  adsq_core_model core (.core_clk(core_clk), .rstn(rstn), .core_cmd(core_cmd), .code_in(code_in),
    .core_valid(core_valid), .core_code(core_code));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    @(posedge core_clk);
    s_awaddr <= {ix, 2'b00};
    s_wdata <= {24'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!(s_bvalid && !s_awvalid && !s_wvalid));
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ix);
    @(posedge core_clk);
    s_araddr <= {ix, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!(s_rvalid && !s_arvalid));
    rd_v = s_rdata[7:0];
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic wr16(input logic [5:0] ix, input logic [15:0] v);
    wr(ix, v[7:0]);
    wr(ix + adsq_pkg::IX_HIGH, v[15:8]);
  endtask

  task automatic pulse_event;
    event_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    event_in <= 1'b0;
  endtask

  task automatic wait_idle;
    do rd(adsq_pkg::IX_CMD); while (rd_v[0] !== 1'b0);
  endtask

  function automatic logic [15:0] exp_res(int c, logic [2:0] a, logic b8);
    int v;
    v = (c < 0) ? 0 : ((c > 1023) ? 1023 : c);
    if (b8) v = v >> 2;
    return 16'(v * ((a == 3'h0 || a == 3'h7) ? 1 : (1 << a)));
  endfunction

  function automatic logic exp_win(logic [2:0] m, logic [15:0] v, logic [15:0] l, logic [15:0] h);
    case (m)
      3'h1: return v < l;
      3'h2: return v > h;
      3'h3: return l < v && v < h;
      3'h4: return v < l || v > h;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [4:0] exp_mux(logic [4:0] m);
    return (m <= adsq_pkg::MUX_PIN_LAST || m == adsq_pkg::MUX_DACREF || m == adsq_pkg::MUX_TEMP) ? m : 5'h1f;
  endfunction

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    $display("FAIL at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, event_in, cpu_halted} = 8'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'h1;
    code_in = 12'h000;
    void'($urandom(32'hf9e5ceb1));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rst_ix[k]) begin
      rd(rst_ix[k]);
      chk(rd_v, 16'h0000);
    end
    rd(6'h3f);
    chk(rsp, adsq_pkg::RESP_ERR);
    wr(6'h3e, 8'h11);
    chk(rsp, adsq_pkg::RESP_ERR);
    wr(adsq_pkg::IX_STAGE, 8'h5a);
    rd(adsq_pkg::IX_STAGE);
    chk(rd_v, 16'h005a);
    for (int i = 0; i < 11; i++) begin
      code = (i == 0) ? 2000 : ((i == 1) ? -7 : ((i == 2) ? 1500 : int'($urandom_range(0, 1100))));
      acc = (i == 0) ? 3'h6 : ((i == 2) ? 3'h7 : 3'($urandom_range(0, 4)));
      {r8, vary, ien, wm, gap} = 11'($urandom);
      r8 = r8 && i > 2;
      ext = 5'($urandom_range(8, 31));
      mux = 5'($urandom);
      lo = 16'($urandom_range(0, 2100));
      hi = 16'($urandom_range(0, 2100));
      r = exp_res(code, acc, r8);
      match = exp_win(wm, r, lo, hi);
      code_in <= 12'(code);
      wr(adsq_pkg::IX_CTRL, {5'h0, r8, 2'b01});
      wr(adsq_pkg::IX_ACC, {5'h0, acc});
      wr(adsq_pkg::IX_GAP, {3'h0, vary, gap});
      wr(adsq_pkg::IX_WINMODE, {5'h0, wm});
      wr(adsq_pkg::IX_SAMPLE_EXTENSION, {3'h0, ext});
      wr(adsq_pkg::IX_INSEL, {3'h0, mux});
      wr16(adsq_pkg::IX_WINLO, lo);
      wr16(adsq_pkg::IX_WINHI, hi);
      rd(adsq_pkg::IX_WINHI);
      chk(rd_v, hi[7:0]);
      rd(adsq_pkg::IX_WINHI + adsq_pkg::IX_HIGH);
      chk(rd_v, hi[15:8]);
      wr(adsq_pkg::IX_IRQEN, {6'h0, ien});
      wr(adsq_pkg::IX_CMD, 8'h01);
      rd(adsq_pkg::IX_CMD);
      chk(rd_v, 16'h0001);
      chk(core_cmd.mux_sel, exp_mux(mux));
      wr(adsq_pkg::IX_INSEL, {3'h0, ~mux});
      chk(core_cmd.mux_sel, exp_mux(mux));
      wait_idle();
      // Flags trail the busy bit by one cycle, request outputs by two cycles
      repeat (2) @(posedge core_clk);
      chk(irq_result_ready, ien[0]);
      chk(irq_window_match, ien[1] & match);
      rd(adsq_pkg::IX_FLAGS);
      chk(rd_v, {match, 1'b1});
      rd(adsq_pkg::IX_GAP);
      n = (acc == 3'h0 || acc == 3'h7) ? 1 : (1 << acc);
      chk(rd_v, {vary, vary ? 4'(gap + n) : gap});
      wr(adsq_pkg::IX_FLAGS, 8'h00);
      rd(adsq_pkg::IX_FLAGS);
      chk(rd_v, {match, 1'b1});
      wr(adsq_pkg::IX_FLAGS, 8'h01);
      rd(adsq_pkg::IX_FLAGS);
      chk(rd_v, {match, 1'b0});
      rd(adsq_pkg::IX_RES);
      chk(rd_v, r[7:0]);
      rd(adsq_pkg::IX_RES + adsq_pkg::IX_HIGH);
      chk(rd_v, r[15:8]);
      rd(adsq_pkg::IX_FLAGS);
      chk(rd_v, 16'h0000);
    end
    wr(adsq_pkg::IX_ACC, 8'h00);
    pulse_event();
    rd(adsq_pkg::IX_CMD);
    chk(rd_v, 16'h0000);
    wr(adsq_pkg::IX_EVENT_TRIGGER_CTRL, 8'h01);
    pulse_event();
    rd(adsq_pkg::IX_CMD);
    chk(rd_v, 16'h0001);
    wait_idle();
    cpu_halted <= 1'b1;
    pulse_event();
    rd(adsq_pkg::IX_CMD);
    chk(rd_v, 16'h0000);
    wr(adsq_pkg::IX_DBG, 8'h01);
    pulse_event();
    rd(adsq_pkg::IX_CMD);
    chk(rd_v, 16'h0001);
    wait_idle();
    cpu_halted <= 1'b0;
    wr(adsq_pkg::IX_CTRL, 8'h03);
    wr(adsq_pkg::IX_CMD, 8'h01);
    n = 0;
    repeat (400) begin
      @(posedge core_clk);
      if (core_cmd.conv_start) n++;
    end
    chk(16'(n > 2), 16'h0001);
    rd(adsq_pkg::IX_CMD);
    chk(rd_v, 16'h0001);
    wr(adsq_pkg::IX_CTRL, 8'h01);
    wait_idle();
    end_of_test();
  end
endmodule
